// file: core.sv
`timescale 1ns/1ps
module core
	import counter_array_pkg::*;
(
	// Register bus, driven at the falling edge.
	input  wire logic       clk,
	output logic [7:0]      sfr_addr = 8'h00,
	output logic [7:0]      sfr_page = 8'h00,
	output logic            sfr_wr = 1'b0,
	output logic [7:0]      sfr_wdata = 8'h00,
	output logic            sfr_rd = 1'b0,
	output logic            sfr_bit_wr = 1'b0,
	output logic [2:0]      sfr_bit_idx = 3'h0,
	output logic            sfr_bit_val = 1'b0,
	input  wire logic [7:0] sfr_rdata,
	input  wire logic       sfr_rvalid
);
	task automatic wr(input logic [7:0] a, p, d);
		@(negedge clk);
		{sfr_addr, sfr_page, sfr_wdata, sfr_wr} = {a, p, d, 1'b1};
		@(negedge clk);
		sfr_wr = 1'b0;
		// Released data must not look like a held value.
		sfr_wdata = ~d;
	endtask
	task automatic rd(input logic [7:0] a, p, output logic [7:0] d);
		@(negedge clk);
		{sfr_addr, sfr_page, sfr_rd} = {a, p, 1'b1};
		@(negedge clk);
		sfr_rd = 1'b0;
		d = sfr_rvalid ? sfr_rdata : 8'hxx;
	endtask
	task automatic bwr(input logic [2:0] i, input logic v);
		@(negedge clk);
		{sfr_addr, sfr_bit_idx, sfr_bit_val, sfr_bit_wr} = {CTRL_ADDR, i, v, 1'b1};
		@(negedge clk);
		sfr_bit_wr = 1'b0;
	endtask
endmodule

// file: counter_array_checker.sv
`timescale 1ns/1ps
module counter_array_checker #(
	parameter int COUNT_WIDTH = 16,
	parameter int N_MODULES   = 3
) (
	// Clock, reset and bus strobes.
	input wire logic                   clk,
	input wire logic                   rst_b,
	input wire logic                   sfr_wr,
	input wire logic                   sfr_bit_wr,
	input wire logic                   sfr_rd,
	input wire logic [7:0]             sfr_rdata,
	input wire logic                   sfr_rvalid,
	// Counter and interrupt.
	input wire logic                   cpu_idle,
	input wire logic [N_MODULES-1:0]   module_irq_enable,
	input wire logic [COUNT_WIDTH-1:0] counter_value,
	input wire logic                   count_tick,
	input wire logic                   array_active,
	input wire logic                   counter_array_irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	a_count_step: assert property (count_tick |=> counter_value == $past(counter_value) + 1'b1)
		else $error("counter did not step");
	a_count_wrap: assert property (count_tick && counter_value == '1 |=> counter_value == '0)
		else $error("counter did not wrap");
	a_count_hold: assert property (!count_tick |=> $stable(counter_value))
		else $error("counter moved without tick");
	a_idle_no_tick: assert property (!array_active |-> !count_tick)
		else $error("tick while suspended");
	a_busy_active: assert property (!cpu_idle |-> array_active)
		else $error("suspended while not idle");
	// A request may only drop after a register write or an enable change.
	a_irq_fall_cause: assert property ($fell(counter_array_irq) |->
		$past(sfr_wr || sfr_bit_wr, 2) || $past(module_irq_enable) != $past(module_irq_enable, 2))
		else $error("request dropped by itself");
	a_read_answer: assert property (sfr_rvalid == $past(sfr_rd))
		else $error("read answer misplaced");
	a_rdata_hold: assert property (!sfr_rvalid |-> $stable(sfr_rdata))
		else $error("read data changed");
endmodule

// file: counter_array_ctrl.sv
`timescale 1ns/1ps

// Function
// - The overflow flag is set when the counter wraps from all ones to zero and only software clears it.
// - With the overflow interrupt enabled, a set overflow flag requests the shared interrupt.
// - Three module event flags sit in control bits 2 to 0, set by a match or capture, cleared by software.
// - A set module event flag whose module interrupt is enabled requests the shared interrupt.
// - The counter advances only while the run bit is one and holds otherwise.
// - With idle suspend set and the processor idle, all counter array activity stops.
// - Mode bits 3 to 1 pick the timebase: 000 clock/12, 001 clock/4, 010 timer 0 overflow, 100 clock.
// - Code 011 counts falling edges of the external count pin, which toggles at most at clock/4.
// - Code 101 counts the external oscillator divided by eight, brought into the clock domain first.
// - Mode bit 0 enables the overflow interrupt request.
// - Unused control bits 5 to 3 and mode bits 6 to 4 read zero and ignore writes.
// - The control register sits at 0xd8 on every page and accepts single-bit writes.
// - The mode register sits at 0xed and answers only when page F is selected.
module counter_array_ctrl
	import counter_array_pkg::*;
#(
	parameter int COUNT_WIDTH = 16,
	parameter int N_MODULES   = 3
) (
	// Clock and reset.
	input  wire logic                   clk,
	input  wire logic                   rst_b,
	// Special-function register bus.
	input  wire logic [7:0]             sfr_addr,
	input  wire logic [7:0]             sfr_page,
	input  wire logic                   sfr_wr,
	input  wire logic [7:0]             sfr_wdata,
	input  wire logic                   sfr_rd,
	input  wire logic                   sfr_bit_wr,
	input  wire logic [2:0]             sfr_bit_idx,
	input  wire logic                   sfr_bit_val,
	output logic      [7:0]             sfr_rdata,
	output logic                        sfr_rvalid,
	// Processor state and timebase sources.
	input  wire logic                   cpu_idle,
	input  wire logic                   timer0_overflow,
	input  wire logic                   external_count_input,
	input  wire logic                   ext_osc_clk,
	// Capture/compare modules.
	input  wire logic [N_MODULES-1:0]   module_event,
	input  wire logic [N_MODULES-1:0]   module_irq_enable,
	output logic      [COUNT_WIDTH-1:0] counter_value,
	output logic                        count_tick,
	output logic                        array_active,
	// Shared interrupt request.
	output logic                        counter_array_irq
);

	if (N_MODULES != 3 || COUNT_WIDTH < 2) begin : g_bad_params
		$error("counter_array_ctrl: three modules and a counter of two bits or more are needed");
	end

	logic                   counter_overflow_flag_ff;
	logic                   counter_run_control_ff;
	logic [N_MODULES-1:0]   module_event_flags_ff;
	logic                   idle_suspend_ff;
	logic [2:0]             timebase_select_ff;
	logic                   overflow_irq_enable_ff;
	logic [COUNT_WIDTH-1:0] counter_ff;
	logic [3:0]             prescale_ff;
	logic [2:0]             eci_sync_ff;
	logic [2:0]             ext_sync_ff;
	logic [2:0]             ext_div_ff;
	logic [7:0]             rdata_ff;
	logic                   rvalid_ff;
	logic                   irq_ff;

	logic                   ctrl_hit;
	logic                   mode_hit;
	logic                   ctrl_byte_wr;
	logic                   ctrl_bit_wr;
	logic                   mode_byte_wr;
	logic                   mode_bit_wr;
	logic                   active;
	logic                   tick;
	logic                   wrap;
	logic                   eci_fall;
	logic                   ext_rise;
	logic [7:0]             ctrl_view;
	logic [7:0]             mode_view;
	logic [7:0]             nxt_ctrl;
	logic [7:0]             nxt_mode;

	// A single-bit write becomes a byte write of the current view with one bit replaced.
	function automatic logic [7:0] bit_merge(input logic [7:0] cur, input logic [2:0] idx,
			input logic val);
		logic [7:0] res;
		res      = cur;
		res[idx] = val;
		return res;
	endfunction

	assign ctrl_hit     = (sfr_addr == CTRL_ADDR);
	assign mode_hit     = (sfr_addr == MODE_ADDR) && (sfr_page == MODE_PAGE);
	assign ctrl_byte_wr = ctrl_hit && sfr_wr;
	assign ctrl_bit_wr  = ctrl_hit && sfr_bit_wr && !sfr_wr;
	assign mode_byte_wr = mode_hit && sfr_wr;
	assign mode_bit_wr  = mode_hit && sfr_bit_wr && !sfr_wr;

	// Unused bits are forced to zero in the view and never stored.
	always_comb begin
		ctrl_view                                         = 8'h00;
		ctrl_view[CTRL_OVF_BIT]                           = counter_overflow_flag_ff;
		ctrl_view[CTRL_RUN_BIT]                           = counter_run_control_ff;
		ctrl_view[CTRL_FLAGS_LSB +: N_MODULES]            = module_event_flags_ff;
		mode_view                                         = 8'h00;
		mode_view[MODE_IDLE_BIT]                          = idle_suspend_ff;
		mode_view[MODE_SEL_LSB +: 3]                      = timebase_select_ff;
		mode_view[MODE_OVF_IE_BIT]                        = overflow_irq_enable_ff;
	end

	always_comb begin
		nxt_ctrl = ctrl_view;
		if (ctrl_byte_wr) begin
			nxt_ctrl = sfr_wdata & CTRL_USED_MASK;
		end else if (ctrl_bit_wr) begin
			nxt_ctrl = bit_merge(ctrl_view, sfr_bit_idx, sfr_bit_val) & CTRL_USED_MASK;
		end
	end

	always_comb begin
		nxt_mode = mode_view;
		if (mode_byte_wr) begin
			nxt_mode = sfr_wdata & MODE_USED_MASK;
		end else if (mode_bit_wr) begin
			nxt_mode = bit_merge(mode_view, sfr_bit_idx, sfr_bit_val) & MODE_USED_MASK;
		end
	end

	// Suspension freezes dividers, counter and flag setting alike.
	assign active = !(idle_suspend_ff && cpu_idle);

	// Edge detectors look only at the second and third synchroniser stages.
	assign eci_fall = eci_sync_ff[2] && !eci_sync_ff[1];
	assign ext_rise = ext_sync_ff[1] && !ext_sync_ff[2];

	always_comb begin
		unique case (timebase_t'(timebase_select_ff))
			TB_SYS_DIV12: begin
				tick = (prescale_ff == PRESCALE_LAST);
			end
			TB_SYS_DIV4: begin
				tick = (prescale_ff[1:0] == DIV4_LAST);
			end
			TB_TIMER0: begin
				tick = timer0_overflow;
			end
			TB_ECI_FALL: begin
				tick = eci_fall;
			end
			TB_SYS: begin
				tick = 1'b1;
			end
			TB_EXT_DIV8: begin
				tick = ext_rise && (ext_div_ff == EXT_DIV_LAST);
			end
			// Reserved codes stay silent so a stray write cannot run the counter away.
			TB_RSVD6: begin
				tick = 1'b0;
			end
			TB_RSVD7: begin
				tick = 1'b0;
			end
		endcase
	end

	// The wrap uses the same condition as the increment, so the flag cannot miss it.
	assign wrap = active && counter_run_control_ff && tick && (&counter_ff);

	// The prescaler runs whether or not the counter runs, so its phase is not restarted.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			prescale_ff <= 4'h0;
		end else if (active) begin
			prescale_ff <= (prescale_ff == PRESCALE_LAST) ? 4'h0 : prescale_ff + 4'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			eci_sync_ff <= 3'h7;
		end else begin
			eci_sync_ff <= {eci_sync_ff[1:0], external_count_input};
		end
	end

	// The oscillator is resampled here, so it must run well below half of clk.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ext_sync_ff <= 3'h0;
		end else begin
			ext_sync_ff <= {ext_sync_ff[1:0], ext_osc_clk};
		end
	end

	// Only synchronised rises are counted; the eighth one makes a tick.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ext_div_ff <= 3'h0;
		end else if (active && ext_rise) begin
			ext_div_ff <= ext_div_ff + 3'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			counter_ff <= '0;
		end else if (active && counter_run_control_ff && tick) begin
			counter_ff <= counter_ff + COUNT_WIDTH'(1);
		end
	end

	// A hardware set in the same cycle as a software clear wins, so no event is lost.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			counter_overflow_flag_ff <= CTRL_RESET[CTRL_OVF_BIT];
		end else begin
			counter_overflow_flag_ff <= nxt_ctrl[CTRL_OVF_BIT] || wrap;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			counter_run_control_ff <= CTRL_RESET[CTRL_RUN_BIT];
		end else begin
			counter_run_control_ff <= nxt_ctrl[CTRL_RUN_BIT];
		end
	end

	// Module events are dropped while suspended, like every other activity.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			module_event_flags_ff <= CTRL_RESET[CTRL_FLAGS_LSB +: N_MODULES];
		end else begin
			module_event_flags_ff <= nxt_ctrl[CTRL_FLAGS_LSB +: N_MODULES]
				| (module_event & {N_MODULES{active}});
		end
	end

	// Mode fields change only by register writes; hardware never touches them.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			idle_suspend_ff <= MODE_RESET[MODE_IDLE_BIT];
		end else begin
			idle_suspend_ff <= nxt_mode[MODE_IDLE_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			timebase_select_ff <= MODE_RESET[MODE_SEL_LSB +: 3];
		end else begin
			timebase_select_ff <= nxt_mode[MODE_SEL_LSB +: 3];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			overflow_irq_enable_ff <= MODE_RESET[MODE_OVF_IE_BIT];
		end else begin
			overflow_irq_enable_ff <= nxt_mode[MODE_OVF_IE_BIT];
		end
	end

	// Request is a level that follows the flags one cycle later.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= (counter_overflow_flag_ff && overflow_irq_enable_ff)
				|| |(module_event_flags_ff & module_irq_enable);
		end
	end

	// Reads answer one cycle later; an unmapped address reads zero.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rvalid_ff <= 1'b0;
		end else begin
			rvalid_ff <= sfr_rd;
		end
	end

	// Read data holds between reads, so a slow core may pick it up late.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rdata_ff <= 8'h00;
		end else if (sfr_rd) begin
			rdata_ff <= ctrl_hit ? ctrl_view : (mode_hit ? mode_view : 8'h00);
		end
	end

	assign sfr_rdata         = rdata_ff;
	assign sfr_rvalid        = rvalid_ff;
	assign counter_value     = counter_ff;
	assign count_tick        = active && counter_run_control_ff && tick;
	assign array_active      = active;
	assign counter_array_irq = irq_ff;

endmodule

// file: counter_array_pkg.sv
package counter_array_pkg;

	// Special-function addresses and paging.
	localparam logic [7:0] CTRL_ADDR        = 8'hd8;
	localparam logic [7:0] MODE_ADDR        = 8'hed;
	localparam logic [7:0] MODE_PAGE        = 8'h0f;

	// Control register fields.
	localparam int         CTRL_OVF_BIT     = 7;
	localparam int         CTRL_RUN_BIT     = 6;
	localparam int         CTRL_FLAGS_LSB   = 0;
	localparam logic [7:0] CTRL_RESET       = 8'h00;
	localparam logic [7:0] CTRL_USED_MASK   = 8'hc7;

	// Mode register fields.
	localparam int         MODE_IDLE_BIT    = 7;
	localparam int         MODE_SEL_LSB     = 1;
	localparam int         MODE_OVF_IE_BIT  = 0;
	localparam logic [7:0] MODE_RESET       = 8'h00;
	localparam logic [7:0] MODE_USED_MASK   = 8'h8f;

	// Timebase select encodings.
	typedef enum logic [2:0] {
		TB_SYS_DIV12 = 3'h0,
		TB_SYS_DIV4  = 3'h1,
		TB_TIMER0    = 3'h2,
		TB_ECI_FALL  = 3'h3,
		TB_SYS       = 3'h4,
		TB_EXT_DIV8  = 3'h5,
		TB_RSVD6     = 3'h6,
		TB_RSVD7     = 3'h7
	} timebase_t;

	// Divider constants.
	localparam logic [3:0] PRESCALE_LAST    = 4'hb;
	localparam logic [1:0] DIV4_LAST        = 2'h3;
	localparam logic [2:0] EXT_DIV_LAST     = 3'h7;

endpackage

// file: test_counter_array_ctrl.sv
`timescale 1ns/1ps
module test_counter_array_ctrl;
	import counter_array_pkg::*;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [7:0]  sfr_addr, sfr_page, sfr_wdata, sfr_rdata, v;
	logic        sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_val, sfr_rvalid;
	logic [2:0]  sfr_bit_idx;
	logic        cpu_idle = 1'b0;
	logic        timer0_overflow = 1'b0;
	logic        external_count_input = 1'b1;
	logic        ext_osc_clk = 1'b0;
	logic [2:0]  module_event = 3'h0;
	logic [2:0]  module_irq_enable = 3'h5;
	logic [15:0] counter_value, d;
	logic        count_tick, array_active, counter_array_irq;
	int          n_errors = 0;
	int          checked = 0;
	int          cyc = 0;
	counter_array_ctrl counter_array_ctrl_inst (.*);
	core core_inst (.*);
	always #12.5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 90000) begin
			n_errors++;
			end_sim();
		end
	end
	task automatic chk(input logic [15:0] s, e);
		checked++;
		if (s !== e) begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic meas(input int n, output logic [15:0] r);
		logic [15:0] s;
		@(negedge clk) s = counter_value;
		repeat (n) @(negedge clk);
		r = counter_value - s;
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic t_regs();
		core_inst.rd(CTRL_ADDR, 8'h00, v); chk(v, CTRL_RESET);
		core_inst.rd(MODE_ADDR, MODE_PAGE, v); chk(v, MODE_RESET);
		core_inst.wr(CTRL_ADDR, 8'h03, 8'h38);
		core_inst.rd(CTRL_ADDR, 8'h00, v); chk(v, 8'h00);
		core_inst.wr(MODE_ADDR, MODE_PAGE, 8'h70);
		core_inst.rd(MODE_ADDR, MODE_PAGE, v); chk(v, 8'h00);
		core_inst.wr(MODE_ADDR, 8'h00, 8'h09);
		core_inst.rd(MODE_ADDR, MODE_PAGE, v); chk(v, 8'h00);
		core_inst.rd(8'h55, 8'h00, v); chk(v, 8'h00);
	endtask
	// Codes 110 and 111 are never written.
	task automatic t_rates();
		core_inst.bwr(3'(CTRL_RUN_BIT), 1'b1);
		core_inst.wr(MODE_ADDR, MODE_PAGE, 8'h00); meas(48, d); chk(d, 16'h4);
		core_inst.wr(MODE_ADDR, MODE_PAGE, 8'h02); meas(48, d); chk(d, 16'hc);
		core_inst.wr(MODE_ADDR, MODE_PAGE, 8'h08); meas(48, d); chk(d, 16'h30);
		core_inst.wr(MODE_ADDR, MODE_PAGE, 8'h04);
		d = counter_value;
		repeat (5) begin
			@(negedge clk) timer0_overflow = 1'b1;
			@(negedge clk) timer0_overflow = 1'b0;
		end
		chk(counter_value - d, 16'h5);
		core_inst.wr(MODE_ADDR, MODE_PAGE, 8'h06);
		d = counter_value;
		repeat (5) begin
			@(negedge clk) external_count_input = 1'b0;
			wait_n(4);
			external_count_input = 1'b1;
			wait_n(4);
		end
		chk(counter_value - d, 16'h5);
		core_inst.wr(MODE_ADDR, MODE_PAGE, 8'h0a);
		d = counter_value;
		repeat (16) begin
			@(negedge clk) ext_osc_clk = 1'b1;
			wait_n(2);
			ext_osc_clk = 1'b0;
			wait_n(2);
		end
		wait_n(4);
		chk(counter_value - d, 16'h2);
	endtask
	task automatic t_stop_idle();
		core_inst.wr(MODE_ADDR, MODE_PAGE, 8'h88);
		core_inst.bwr(3'(CTRL_RUN_BIT), 1'b0);
		meas(20, d); chk(d, 16'h0);
		core_inst.bwr(3'(CTRL_RUN_BIT), 1'b1);
		cpu_idle = 1'b1;
		meas(20, d); chk(d, 16'h0);
		core_inst.wr(MODE_ADDR, MODE_PAGE, 8'h08);
		meas(20, d); chk(d, 16'h14);
		cpu_idle = 1'b0;
	endtask
	task automatic t_ovf();
		core_inst.wr(MODE_ADDR, MODE_PAGE, 8'h09);
		for (int i = 0; i < 70000 && counter_value !== 16'h0; i++) @(negedge clk);
		wait_n(1); chk(counter_array_irq, 1'b1);
		core_inst.rd(CTRL_ADDR, 8'h00, v); chk(v, 8'hc0);
		core_inst.wr(MODE_ADDR, MODE_PAGE, 8'h08);
		wait_n(2); chk(counter_array_irq, 1'b0);
		core_inst.wr(MODE_ADDR, MODE_PAGE, 8'h09);
		wait_n(2); chk(counter_array_irq, 1'b1);
		core_inst.bwr(3'(CTRL_OVF_BIT), 1'b0);
		wait_n(2); chk(counter_array_irq, 1'b0);
		core_inst.bwr(3'(CTRL_RUN_BIT), 1'b0);
	endtask
	task automatic pulse(input logic [2:0] e);
		@(negedge clk) module_event = e;
		@(negedge clk) module_event = 3'h0;
		wait_n(2);
	endtask
	task automatic t_events();
		pulse(3'h2); chk(counter_array_irq, 1'b0);
		core_inst.rd(CTRL_ADDR, 8'h00, v); chk(v, 8'h02);
		pulse(3'h4); chk(counter_array_irq, 1'b1);
		core_inst.wr(CTRL_ADDR, 8'h00, 8'h00);
		wait_n(2); chk(counter_array_irq, 1'b0);
		core_inst.rd(CTRL_ADDR, 8'h00, v); chk(v, 8'h00);
	endtask
	task automatic end_sim();
		if (n_errors == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		wait_n(4);
		rst_b = 1'b1;
		t_regs();
		t_rates();
		t_stop_idle();
		t_ovf();
		t_events();
		end_sim();
	end
endmodule
bind counter_array_ctrl counter_array_checker #(.COUNT_WIDTH(COUNT_WIDTH),
	.N_MODULES(N_MODULES)) counter_array_checker_inst (.*);
